// ---- design/bao_pkg.sv ----
// Purpose: shared constants for the byte alu and bit-op execution block
// Assumes: AHB-Lite slave, 32-bit data, one aligned word per register
// Notes: command word fields are packed into one register write
// How it works
// - immediate add: acc plus 8-bit literal into acc, updates carry, nibble carry, zero
// - file add: acc plus addressed file register, updates carry, nibble carry, zero
// - file operations: destination 0 writes acc, destination 1 writes file register
// - immediate and: acc and literal into acc, only zero flag changes
// - file and: acc and file register, routed by destination, only zero changes
// - clear bit: selected file register bit forced low, all else unchanged
// - set bit: selected file register bit forced high, all else unchanged
// - skip if low: zero bit discards next instruction as nop, no flags change
// - skip if high: one bit discards next instruction as nop, no flags change
// - watchdog kick clears watchdog counter and its prescaler
// - watchdog kick sets expiry flag and sleep entry flag to one
package bao_pkg;

  localparam int unsigned BAO_DATA_W = 8;
  localparam int unsigned BAO_FADDR_W = 7;
  localparam int unsigned BAO_FILE_DEPTH = 128;

  // register byte offsets
  localparam logic [7:0] BAO_CMD_OFS = 8'h00;
  localparam logic [7:0] BAO_ACC_OFS = 8'h04;
  localparam logic [7:0] BAO_STATUS_OFS = 8'h08;
  localparam logic [7:0] BAO_FADDR_OFS = 8'h0c;
  localparam logic [7:0] BAO_FDATA_OFS = 8'h10;
  localparam logic [7:0] BAO_WDT_OFS = 8'h14;

  // command word fields
  localparam int unsigned BAO_CMD_LIT_LSB = 0;
  localparam int unsigned BAO_CMD_FADDR_LSB = 8;
  localparam int unsigned BAO_CMD_BIT_LSB = 15;
  localparam int unsigned BAO_CMD_DEST_POS = 18;
  localparam int unsigned BAO_CMD_OP_LSB = 20;

  // status register bit positions
  localparam int unsigned BAO_ST_CARRY = 0;
  localparam int unsigned BAO_ST_NIBBLE = 1;
  localparam int unsigned BAO_ST_ZERO = 2;
  localparam int unsigned BAO_ST_SLEEP = 3;
  localparam int unsigned BAO_ST_EXPIRY = 4;
  localparam int unsigned BAO_ST_SKIP = 5;

  // reset values
  localparam logic [7:0] BAO_ACC_RST = 8'h00;
  localparam logic BAO_FLAG_RST = 1'b0;
  localparam logic BAO_WDT_FLAG_RST = 1'b1;
  localparam logic [6:0] BAO_FADDR_RST = 7'h00;
  localparam logic [7:0] BAO_FILE_RST = 8'h00;

  // destination select encodings
  localparam logic BAO_DEST_ACC = 1'b0;
  localparam logic BAO_DEST_FILE = 1'b1;

  // watchdog default widths
  localparam int unsigned BAO_WDT_PRESC_W = 8;
  localparam int unsigned BAO_WDT_CNT_W = 8;

  // operation codes in the command word
  localparam logic [3:0] BAO_OP_NOP = 4'h0;
  localparam logic [3:0] BAO_OP_ADD_IMM = 4'h1;
  localparam logic [3:0] BAO_OP_ADD_FILE = 4'h2;
  localparam logic [3:0] BAO_OP_AND_IMM = 4'h3;
  localparam logic [3:0] BAO_OP_AND_FILE = 4'h4;
  localparam logic [3:0] BAO_OP_CLR_BIT = 4'h5;
  localparam logic [3:0] BAO_OP_SET_BIT = 4'h6;
  localparam logic [3:0] BAO_OP_SKIP_LOW = 4'h7;
  localparam logic [3:0] BAO_OP_SKIP_HIGH = 4'h8;
  localparam logic [3:0] BAO_OP_WDT_KICK = 4'h9;

  localparam logic [1:0] BAO_HTRANS_NONSEQ = 2'h2;

endpackage

// ---- design/bao_file_regs.sv ----
// Purpose: general file register storage, flip-flops addressed by index
// Assumes: one combinational read port, one write port, same clock
// Notes: a write shows on the read port from the next cycle
`timescale 1ns/1ps
module bao_file_regs #(
  parameter int unsigned DEPTH = bao_pkg::BAO_FILE_DEPTH,
  parameter int unsigned WIDTH = bao_pkg::BAO_DATA_W,
  parameter int unsigned AW = bao_pkg::BAO_FADDR_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_en) begin
      next_mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rst) begin
        mem[i] <= WIDTH'(bao_pkg::BAO_FILE_RST);
      end else begin
        mem[i] <= next_mem[i];
      end
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

// ---- design/bao_core.sv ----
// Purpose: executes add, and, bit-op, bit-skip and watchdog-kick commands
// Assumes: AHB-Lite single-word transfers, one master, 20 MHz core_clk
// Notes: writes are zero-wait; reads insert one wait state
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module bao_core #(
  parameter int unsigned PRESC_W = bao_pkg::BAO_WDT_PRESC_W,
  parameter int unsigned CNT_W = bao_pkg::BAO_WDT_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  typedef enum logic [1:0] {
    st_idle,
    st_wr,
    st_rd_wait,
    st_rd_done
  } bao_bus_e;

  function automatic logic bao_is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // bus data-phase tracking
  bao_bus_e bus_st;
  bao_bus_e next_bus_st;
  logic [7:0] dp_addr;
  logic [7:0] next_dp_addr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // architectural state
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic carry_flag;
  logic next_carry_flag;
  logic nibble_carry_flag;
  logic next_nibble_carry_flag;
  logic zero_flag;
  logic next_zero_flag;
  logic watchdog_expiry_flag;
  logic next_watchdog_expiry_flag;
  logic sleep_entry_flag;
  logic next_sleep_entry_flag;
  logic skip_pending;
  logic next_skip_pending;
  logic [6:0] file_addr;
  logic [6:0] next_file_addr;
  logic [31:0] last_cmd;
  logic [31:0] next_last_cmd;

  // watchdog
  logic [PRESC_W-1:0] wdt_presc;
  logic [PRESC_W-1:0] next_wdt_presc;
  logic [CNT_W-1:0] wdt_cnt;
  logic [CNT_W-1:0] next_wdt_cnt;

  // command decode
  logic addr_take;
  logic wr_phase;
  logic cmd_fire;
  logic exec_en;
  logic [3:0] cmd_op;
  logic [7:0] cmd_lit;
  logic [6:0] cmd_faddr;
  logic [2:0] cmd_bit;
  logic cmd_dest;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic fr_wr_en;
  logic [6:0] fr_wr_addr;
  logic [7:0] fr_wr_data;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] and_res;
  logic [7:0] operand;
  logic sel_bit;
  logic wdt_kick;
  logic wdt_expire;

  assign addr_take = hsel && hready && (htrans == bao_pkg::BAO_HTRANS_NONSEQ);
  assign wr_phase = (bus_st == st_wr);
  assign cmd_fire = wr_phase && (dp_addr == bao_pkg::BAO_CMD_OFS);

  assign cmd_op = hwdata[bao_pkg::BAO_CMD_OP_LSB +: 4];
  assign cmd_lit = hwdata[bao_pkg::BAO_CMD_LIT_LSB +: 8];
  assign cmd_faddr = hwdata[bao_pkg::BAO_CMD_FADDR_LSB +: 7];
  assign cmd_bit = hwdata[bao_pkg::BAO_CMD_BIT_LSB +: 3];
  assign cmd_dest = hwdata[bao_pkg::BAO_CMD_DEST_POS];

  // a pending skip turns this command into a nop
  assign exec_en = cmd_fire && !skip_pending;

  // execution and bus reads never share a cycle, so one read port serves both
  assign rd_addr = cmd_fire ? cmd_faddr : file_addr;

  assign operand = ((cmd_op == bao_pkg::BAO_OP_ADD_FILE) ||
                    (cmd_op == bao_pkg::BAO_OP_AND_FILE)) ? rd_data : cmd_lit;
  // carry out of bit 7 and bit 3
  assign sum9 = {1'b0, acc} + {1'b0, operand};
  assign nib5 = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
  assign and_res = acc & operand;
  assign sel_bit = rd_data[cmd_bit];

  assign wdt_kick = exec_en && (cmd_op == bao_pkg::BAO_OP_WDT_KICK);
  assign wdt_expire = (&wdt_presc) && (&wdt_cnt);

  bao_file_regs #(
    .DEPTH(bao_pkg::BAO_FILE_DEPTH),
    .WIDTH(bao_pkg::BAO_DATA_W),
    .AW(bao_pkg::BAO_FADDR_W)
  ) u_file_regs (
    .core_clk(core_clk),
    .rst(rst),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(fr_wr_en),
    .wr_addr(fr_wr_addr),
    .wr_data(fr_wr_data)
  );

  // bus slave sequencing
  always_comb begin
    next_bus_st = bus_st;
    next_dp_addr = dp_addr;
    next_rdata = rdata;
    case (bus_st)
      st_rd_wait: begin
        // read captured a cycle late so writes from the previous data phase show
        next_bus_st = st_rd_done;
        next_rdata = 32'h0000_0000;
        case (dp_addr)
          bao_pkg::BAO_CMD_OFS: next_rdata = last_cmd;
          bao_pkg::BAO_ACC_OFS: next_rdata = {24'h00_0000, acc};
          bao_pkg::BAO_STATUS_OFS: begin
            next_rdata[bao_pkg::BAO_ST_CARRY] = carry_flag;
            next_rdata[bao_pkg::BAO_ST_NIBBLE] = nibble_carry_flag;
            next_rdata[bao_pkg::BAO_ST_ZERO] = zero_flag;
            next_rdata[bao_pkg::BAO_ST_SLEEP] = sleep_entry_flag;
            next_rdata[bao_pkg::BAO_ST_EXPIRY] = watchdog_expiry_flag;
            next_rdata[bao_pkg::BAO_ST_SKIP] = skip_pending;
          end
          bao_pkg::BAO_FADDR_OFS: next_rdata = {25'h000_0000, file_addr};
          bao_pkg::BAO_FDATA_OFS: next_rdata = {24'h00_0000, rd_data};
          bao_pkg::BAO_WDT_OFS: begin
            next_rdata = 32'h0000_0000;
            next_rdata[15:0] = {8'(wdt_cnt), 8'(wdt_presc)};
          end
          default: next_rdata = 32'h0000_0000;
        endcase
      end
      st_idle, st_wr, st_rd_done: begin
        if (addr_take) begin
          next_bus_st = hwrite ? st_wr : st_rd_wait;
          next_dp_addr = haddr[7:0];
        end else begin
          next_bus_st = st_idle;
        end
      end
      default: next_bus_st = st_idle;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_st <= st_idle;
      dp_addr <= 8'h00;
      rdata <= 32'h0000_0000;
    end else begin
      bus_st <= next_bus_st;
      dp_addr <= next_dp_addr;
      rdata <= next_rdata;
    end
  end

  assign hreadyout = (bus_st != st_rd_wait);
  assign hresp = 1'b0;
  assign hrdata = rdata;

  // execution and software writes
  always_comb begin
    next_acc = acc;
    next_carry_flag = carry_flag;
    next_nibble_carry_flag = nibble_carry_flag;
    next_zero_flag = zero_flag;
    next_skip_pending = skip_pending;
    next_file_addr = file_addr;
    next_last_cmd = last_cmd;
    fr_wr_en = 1'b0;
    fr_wr_addr = cmd_faddr;
    fr_wr_data = rd_data;
    if (wr_phase) begin
      case (dp_addr)
        bao_pkg::BAO_ACC_OFS: next_acc = hwdata[7:0];
        bao_pkg::BAO_STATUS_OFS: begin
          next_carry_flag = hwdata[bao_pkg::BAO_ST_CARRY];
          next_nibble_carry_flag = hwdata[bao_pkg::BAO_ST_NIBBLE];
          next_zero_flag = hwdata[bao_pkg::BAO_ST_ZERO];
        end
        bao_pkg::BAO_FADDR_OFS: next_file_addr = hwdata[6:0];
        bao_pkg::BAO_FDATA_OFS: begin
          fr_wr_en = 1'b1;
          fr_wr_addr = file_addr;
          fr_wr_data = hwdata[7:0];
        end
        default: next_last_cmd = last_cmd;
      endcase
    end
    if (cmd_fire) begin
      next_last_cmd = hwdata;
    end
    if (cmd_fire && skip_pending) begin
      // discarded command runs as a nop
      next_skip_pending = 1'b0;
    end
    if (exec_en) begin
      case (cmd_op)
        bao_pkg::BAO_OP_ADD_IMM: begin
          next_acc = sum9[7:0];
          next_carry_flag = sum9[8];
          next_nibble_carry_flag = nib5[4];
          next_zero_flag = bao_is_zero(sum9[7:0]);
        end
        bao_pkg::BAO_OP_ADD_FILE: begin
          next_carry_flag = sum9[8];
          next_nibble_carry_flag = nib5[4];
          next_zero_flag = bao_is_zero(sum9[7:0]);
          if (cmd_dest == bao_pkg::BAO_DEST_FILE) begin
            fr_wr_en = 1'b1;
            fr_wr_data = sum9[7:0];
          end else begin
            next_acc = sum9[7:0];
          end
        end
        bao_pkg::BAO_OP_AND_IMM: begin
          next_acc = and_res;
          next_zero_flag = bao_is_zero(and_res);
        end
        bao_pkg::BAO_OP_AND_FILE: begin
          next_zero_flag = bao_is_zero(and_res);
          if (cmd_dest == bao_pkg::BAO_DEST_FILE) begin
            fr_wr_en = 1'b1;
            fr_wr_data = and_res;
          end else begin
            next_acc = and_res;
          end
        end
        bao_pkg::BAO_OP_CLR_BIT: begin
          fr_wr_en = 1'b1;
          fr_wr_data = rd_data & ~(8'h01 << cmd_bit);
        end
        bao_pkg::BAO_OP_SET_BIT: begin
          fr_wr_en = 1'b1;
          fr_wr_data = rd_data | (8'h01 << cmd_bit);
        end
        bao_pkg::BAO_OP_SKIP_LOW: begin
          next_skip_pending = !sel_bit;
        end
        bao_pkg::BAO_OP_SKIP_HIGH: begin
          next_skip_pending = sel_bit;
        end
        default: next_skip_pending = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc <= bao_pkg::BAO_ACC_RST;
      carry_flag <= bao_pkg::BAO_FLAG_RST;
      nibble_carry_flag <= bao_pkg::BAO_FLAG_RST;
      zero_flag <= bao_pkg::BAO_FLAG_RST;
      skip_pending <= 1'b0;
      file_addr <= bao_pkg::BAO_FADDR_RST;
      last_cmd <= 32'h0000_0000;
    end else begin
      acc <= next_acc;
      carry_flag <= next_carry_flag;
      nibble_carry_flag <= next_nibble_carry_flag;
      zero_flag <= next_zero_flag;
      skip_pending <= next_skip_pending;
      file_addr <= next_file_addr;
      last_cmd <= next_last_cmd;
    end
  end

  // watchdog counter, prescaler and its status flags
  always_comb begin
    next_wdt_presc = wdt_presc + PRESC_W'(1);
    next_wdt_cnt = wdt_cnt;
    next_watchdog_expiry_flag = watchdog_expiry_flag;
    next_sleep_entry_flag = sleep_entry_flag;
    if (&wdt_presc) begin
      next_wdt_cnt = wdt_cnt + CNT_W'(1);
    end
    if (wdt_expire) begin
      // flag is active low: a timeout drives it to zero
      next_watchdog_expiry_flag = 1'b0;
    end
    if (wdt_kick) begin
      next_wdt_presc = '0;
      next_wdt_cnt = '0;
      // both flags set, winning over a same-cycle timeout
      next_watchdog_expiry_flag = 1'b1;
      next_sleep_entry_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdt_presc <= '0;
      wdt_cnt <= '0;
      watchdog_expiry_flag <= bao_pkg::BAO_WDT_FLAG_RST;
      sleep_entry_flag <= bao_pkg::BAO_WDT_FLAG_RST;
    end else begin
      wdt_presc <= next_wdt_presc;
      wdt_cnt <= next_wdt_cnt;
      watchdog_expiry_flag <= next_watchdog_expiry_flag;
      sleep_entry_flag <= next_sleep_entry_flag;
    end
  end

endmodule

// ---- sim/bao_core_asserts.sv ----
// Purpose: bus timing and command side-effect checks on bao_core ports
// Assumes: one master, no pipelined transfers
// Notes: a command preceded by a skip may be discarded, so it is not trusted
`timescale 1ns/1ps
module bao_core_asserts #(
  parameter int unsigned PRESC_W = 8,
  parameter int unsigned CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  logic taken, cmd_end, wr_ph, rd_ph, fresh, next_wr_ph, next_rd_ph, next_fresh, cmd_ok;
  logic [7:0] ph_a, next_ph_a, lit, next_lit;
  logic [3:0] op, prev_op, next_op, next_prev;
  assign taken = hsel && hready && htrans == bao_pkg::BAO_HTRANS_NONSEQ;
  assign cmd_end = wr_ph && hready && ph_a == bao_pkg::BAO_CMD_OFS;
  assign cmd_ok = fresh && prev_op != bao_pkg::BAO_OP_SKIP_LOW
    && prev_op != bao_pkg::BAO_OP_SKIP_HIGH;
  always_comb begin
    next_wr_ph = taken ? hwrite : (hready ? 1'b0 : wr_ph);
    next_rd_ph = taken ? !hwrite : (hready ? 1'b0 : rd_ph);
    next_ph_a = taken ? haddr[7:0] : ph_a;
    next_op = cmd_end ? hwdata[23:20] : op;
    next_prev = cmd_end ? op : prev_op;
    next_lit = cmd_end ? hwdata[7:0] : lit;
    next_fresh = cmd_end || (fresh && !taken);
  end
  always_ff @(posedge core_clk) begin
    ph_a <= next_ph_a;
    lit <= next_lit;
    if (rst) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      fresh <= 1'b0;
      op <= bao_pkg::BAO_OP_NOP;
      prev_op <= bao_pkg::BAO_OP_NOP;
    end else begin
      wr_ph <= next_wr_ph;
      rd_ph <= next_rd_ph;
      fresh <= next_fresh;
      op <= next_op;
      prev_op <= next_prev;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_read_one_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase lacks exactly one wait state");
  a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("ready low for more than one cycle");
  a_low_in_read: assert property (!hreadyout |-> rd_ph)
    else $error("ready low outside a read data phase");
  a_unmapped_zero: assert property (taken && !hwrite && haddr[7:0] > 8'h14 |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_kick_flags: assert property (taken && !hwrite && cmd_ok
    && haddr[7:0] == bao_pkg::BAO_STATUS_OFS && op == bao_pkg::BAO_OP_WDT_KICK
    |=> ##1 hrdata[4:3] == 2'b11) else $error("kick left status flags low");
  a_kick_counter: assert property (taken && !hwrite && cmd_ok
    && haddr[7:0] == bao_pkg::BAO_WDT_OFS && op == bao_pkg::BAO_OP_WDT_KICK
    |=> ##1 hrdata[8 +: CNT_W] == {CNT_W{1'b0}}) else $error("kick left counter running");
  a_and_zero: assert property (taken && !hwrite && cmd_ok && lit == 8'h00
    && haddr[7:0] == bao_pkg::BAO_STATUS_OFS && op == bao_pkg::BAO_OP_AND_IMM
    |=> ##1 hrdata[2] == 1'b1) else $error("and with zero literal left zero flag low");
endmodule
bind bao_core bao_core_asserts #(.PRESC_W(PRESC_W), .CNT_W(CNT_W)) u_chk (.core_clk(core_clk),
  .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ---- sim/byte_alu_bit_ops_subset_tb.sv ----
// Purpose: random command stream on bao_core checked against an integer model
// Assumes: shortened watchdog widths of 2 and 2
// Notes: watchdog expiry bit is only checked after reset and around a kick
`timescale 1ns/1ps
module byte_alu_bit_ops_subset_tb;
  localparam logic [7:0] ST = bao_pkg::BAO_STATUS_OFS;
  logic core_clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int bad_count, check_count, acc, cy, dc, zf, skp, v, r, fa;
  int fr[128];
  bao_core #(.PRESC_W(2), .CNT_W(2)) dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready and read data are taken at the rising edge that ends the phase
  task automatic wait_rdy;
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok) begin
      @(posedge core_clk);
      ok = (hreadyout === 1'b1);
      rd = hrdata;
      n++;
      if (n > 20) begin
        bad_count++;
        wrap_up();
      end
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= bao_pkg::BAO_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic cmd(input int o, input int l, input int f, input int b, input int d);
    bus(1'b1, bao_pkg::BAO_CMD_OFS, (o << 20) | (d << 18) | (b << 15) | (f << 8) | l);
    if (skp != 0) begin
      skp = 0;
    end else if (o == 1 || o == 2) begin
      r = (o == 1) ? l : fr[f];
      v = acc + r;
      dc = (acc % 16 + r % 16) > 15;
      cy = v > 255;
      zf = v % 256 == 0;
      if (o == 2 && d == 1) fr[f] = v % 256;
      else acc = v % 256;
    end else if (o == 3 || o == 4) begin
      v = acc & ((o == 3) ? l : fr[f]);
      zf = v == 0;
      if (o == 4 && d == 1) fr[f] = v;
      else acc = v;
    end else if (o == 5) fr[f] = fr[f] & ~(1 << b);
    else if (o == 6) fr[f] = fr[f] | (1 << b);
    else if (o == 7) skp = ((fr[f] >> b) & 1) == 0;
    else if (o == 8) skp = (fr[f] >> b) & 1;
  endtask
  initial begin
    bad_count = 0;
    check_count = 0;
    {acc, cy, dc, zf, skp} = '0;
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    v = $urandom(32'h4599);
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, bao_pkg::BAO_ACC_OFS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h18);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      fa = (i == 7) ? 127 : i;
      fr[fa] = $urandom % 256;
      bus(1'b1, bao_pkg::BAO_FADDR_OFS, fa);
      bus(1'b1, bao_pkg::BAO_FDATA_OFS, fr[fa]);
    end
    // ops 1 to 8 (no nop or watchdog kick), both destinations, literal edges 255 and 0
    for (int i = 0; i < 240; i++) begin
      r = $urandom % 8;
      fa = (r == 7) ? 127 : r;
      v = (i < 8) ? 255 : ((i % 16 == 2) ? 0 : $urandom % 256);
      cmd(1 + i % 8, v, fa, $urandom % 8, $urandom % 2);
      bus(1'b0, ST, 32'h0);
      chk(rd & 32'h2f, 8 | (skp << 5) | (zf << 2) | (dc << 1) | cy);
      bus(1'b0, bao_pkg::BAO_ACC_OFS, 32'h0);
      chk(rd, acc);
      bus(1'b1, bao_pkg::BAO_FADDR_OFS, fa);
      bus(1'b0, bao_pkg::BAO_FDATA_OFS, 32'h0);
      chk(rd, fr[fa]);
    end
    cmd(0, 0, 0, 0, 0);
    repeat (40) @(posedge core_clk);
    bus(1'b0, ST, 32'h0);
    chk(rd & 32'h10, 32'h0);
    cmd(9, 0, 0, 0, 0);
    bus(1'b0, ST, 32'h0);
    chk(rd & 32'h3f, 8'h18 | (zf << 2) | (dc << 1) | cy);
    cmd(9, 0, 0, 0, 0);
    bus(1'b0, bao_pkg::BAO_WDT_OFS, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h0);
    // prescaler restarts at the kick and counts one cycle before the wait-state capture
    chk({24'h0, rd[7:0]}, 32'h1);
    wrap_up();
  end
endmodule
